// ---- rtc_consts.vh ----
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

// register byte addresses (word aligned)
`define ADDR_TIME_WIN 12'h000
`define ADDR_ALARM_WIN 12'h004
`define ADDR_CFG_CAL 12'h008
`define ADDR_ALARM_CFG 12'h00C
`define ADDR_PWR_CTRL 12'h010
`define ADDR_UNLOCK_KEY 12'h014
`define ADDR_REF_STATUS 12'h018

// field positions
`define PTR_LO 8
`define PTR_HI 9
`define WREN_BIT 13
`define CLKSEL_LO 8
`define CLKSEL_HI 9

// pointer codes
`define PTR_MIN_SEC 2'h0
`define PTR_WD_HR 2'h1
`define PTR_MON_DAY 2'h2
`define PTR_YEAR 2'h3

// clock source codes
`define CLK_SECONDARY_OSCILLATOR 2'h0
`define CLK_LOW_POWER_RC_OSCILLATOR 2'h1
`define CLK_LINE50 2'h2
`define CLK_LINE60 2'h3

// unlock key bytes
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA

// byte lane masks
`define LANE_LOW 4'h1
`define LANE_HIGH 4'h2

`endif

// ---- ptr_step.v ----
`timescale 1ns/1ps
`default_nettype none
// 2-bit down counter that saturates at zero, loadable by software
module ptr_step (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire load,
    input wire [1:0] load_val,
    input wire step,
    output wire [1:0] ptr
);
    reg [1:0] ptr_ff;
    reg [1:0] nxt_ptr;

    // load beats a step in the same cycle; at most one step per access whatever its width
    always @* begin
        nxt_ptr = ptr_ff;
        if (load) begin
            nxt_ptr = load_val;
        end else if (step && (ptr_ff != 2'h0)) begin
            nxt_ptr = ptr_ff - 2'h1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_ff <= 2'h0;
        end else if (clk_en) begin
            ptr_ff <= nxt_ptr;
        end
    end

    assign ptr = ptr_ff;
endmodule
`default_nettype wire

// ---- two_ff_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for an asynchronous level
module two_ff_sync (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire async_in,
    output wire sync_out
);
    reg meta_ff;
    reg sync_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else if (clk_en) begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule
`default_nettype wire

// ---- rtc_window_access.v ----
// Notes on behaviour
// RULE1: the time window shows minutes/seconds, weekday/hours, month/day or year only, by time pointer.
// RULE2: a write touching the time window high byte steps the time pointer down, stopping at 00.
// RULE3: the alarm window shows alarm minutes/seconds, weekday/hours, month/day, or nothing for 11.
// RULE4: a write touching the alarm window high byte steps the alarm pointer down, stopping at 00.
// RULE5: any read of the alarm window steps the alarm pointer down.
// RULE6: any read of the time window steps the time pointer down.
// RULE7: writes to time value registers are ignored unless the write-enable bit 13 is set.
// RULE8: the write-enable bit can be set only in the access right after the 55h then AAh key.
// RULE9: software keeps the write-enable bit clear except while updating the time registers.
// RULE10: clock select 00 picks the secondary oscillator, 01 the low-power RC oscillator.
// RULE11: clock select 10 and 11 pick the power line input at 50 Hz and 60 Hz.
// RULE12: one access covering both bytes steps its pointer only once, saturating on reads and writes.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"
module rtc_window_access #(
    parameter ADDR_W = 12
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire secondary_oscillator,
    input wire low_power_rc_oscillator,
    input wire line_clock,
    output reg ref_clock,
    output reg line_60hz
);
    // calendar and alarm storage
    reg [7:0] minutes_ff, seconds_ff, weekday_ff, hours_ff, month_ff, day_ff, year_ff;
    reg [7:0] alarm_minutes_ff, alarm_seconds_ff, alarm_weekday_ff, alarm_hours_ff;
    reg [7:0] alarm_month_ff, alarm_day_of_month_ff;
    // configuration
    reg timer_write_enable_ff;
    reg [15:0] cfg_rest_ff; // other bits of the config/calibration register, plain storage
    reg [15:0] alarm_cfg_rest_ff;
    reg [1:0] reference_clock_select_ff;
    reg [1:0] key_state_ff; // 0 idle, 1 saw 55h, 2 saw AAh (armed for one access)

    localparam KEY_IDLE = 2'h0;
    localparam KEY_GOT1 = 2'h1;
    localparam KEY_ARMED = 2'h2;

    wire [1:0] time_pointer;
    wire [1:0] alarm_pointer;
    wire secondary_oscillator_s, low_power_rc_oscillator_s, line_s;

    // access is taken on the single access-phase edge; slave is zero wait state
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire [ADDR_W-1:0] a = paddr;
    wire hit_time = (a == `ADDR_TIME_WIN);
    wire hit_alarm = (a == `ADDR_ALARM_WIN);
    wire hit_cfg = (a == `ADDR_CFG_CAL);
    wire hit_acfg = (a == `ADDR_ALARM_CFG);
    wire hit_pwr = (a == `ADDR_PWR_CTRL);
    wire hit_key = (a == `ADDR_UNLOCK_KEY);
    wire hit_stat = (a == `ADDR_REF_STATUS);
    wire mapped = hit_time | hit_alarm | hit_cfg | hit_acfg | hit_pwr | hit_key | hit_stat;
    wire lo_lane = |(pstrb & `LANE_LOW);
    wire hi_lane = |(pstrb & `LANE_HIGH);
    wire timer_wr_ok = timer_write_enable_ff; // RULE7

    // pointer stepping: one step per read or high-lane write, whatever lanes the access covers
    wire time_step = hit_time && ((wr && hi_lane) || rd); // RULE2 RULE6 RULE12
    wire alarm_step = hit_alarm && ((wr && hi_lane) || rd); // RULE4 RULE5 RULE12
    wire cfg_lo_wr = wr && hit_cfg && hi_lane;
    wire acfg_ptr_wr = wr && hit_acfg && hi_lane;

    ptr_step u_time_ptr (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .load(cfg_lo_wr),
        .load_val(pwdata[`PTR_HI:`PTR_LO]),
        .step(time_step),
        .ptr(time_pointer)
    );

    ptr_step u_alarm_ptr (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .load(acfg_ptr_wr),
        .load_val(pwdata[`PTR_HI:`PTR_LO]),
        .step(alarm_step),
        .ptr(alarm_pointer)
    );

    // reference clock inputs arrive asynchronously
    two_ff_sync u_sync_secondary_oscillator (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .async_in(secondary_oscillator),
        .sync_out(secondary_oscillator_s)
    );

    two_ff_sync u_sync_low_power_rc_oscillator (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .async_in(low_power_rc_oscillator),
        .sync_out(low_power_rc_oscillator_s)
    );

    two_ff_sync u_sync_line (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .async_in(line_clock),
        .sync_out(line_s)
    );

    // window read mux
    reg [15:0] time_view;
    reg [15:0] alarm_view;
    always @* begin
        case (time_pointer) // RULE1
            `PTR_MIN_SEC: time_view = {minutes_ff, seconds_ff};
            `PTR_WD_HR: time_view = {weekday_ff, hours_ff};
            `PTR_MON_DAY: time_view = {month_ff, day_ff};
            default: time_view = {8'h00, year_ff};
        endcase
        case (alarm_pointer) // RULE3
            `PTR_MIN_SEC: alarm_view = {alarm_minutes_ff, alarm_seconds_ff};
            `PTR_WD_HR: alarm_view = {alarm_weekday_ff, alarm_hours_ff};
            `PTR_MON_DAY: alarm_view = {alarm_month_ff, alarm_day_of_month_ff};
            default: alarm_view = 16'h0000;
        endcase
    end

    // config register as read back: pointer in 9:8, write enable in 13
    reg [15:0] cfg_view;
    reg [15:0] acfg_view;
    always @* begin
        cfg_view = cfg_rest_ff;
        cfg_view[`PTR_HI:`PTR_LO] = time_pointer;
        cfg_view[`WREN_BIT] = timer_write_enable_ff;
        acfg_view = alarm_cfg_rest_ff;
        acfg_view[`PTR_HI:`PTR_LO] = alarm_pointer;
    end

    reg [31:0] nxt_prdata;
    always @* begin
        nxt_prdata = 32'h0000_0000;
        if (hit_time) begin
            nxt_prdata = {16'h0000, time_view};
        end else if (hit_alarm) begin
            nxt_prdata = {16'h0000, alarm_view};
        end else if (hit_cfg) begin
            nxt_prdata = {16'h0000, cfg_view};
        end else if (hit_acfg) begin
            nxt_prdata = {16'h0000, acfg_view};
        end else if (hit_pwr) begin
            nxt_prdata = {22'h000000, reference_clock_select_ff, 8'h00};
        end else if (hit_stat) begin
            nxt_prdata = {29'h00000000, line_60hz, ref_clock, timer_write_enable_ff};
        end
    end

    // key sequence: 55h then AAh, armed for only the next access
    reg [1:0] nxt_key_state;
    always @* begin
        nxt_key_state = key_state_ff;
        if (access) begin
            if (wr && hit_key && lo_lane && pwdata[7:0] == `KEY_FIRST) begin
                nxt_key_state = KEY_GOT1;
            end else if (wr && hit_key && lo_lane && pwdata[7:0] == `KEY_SECOND && key_state_ff == KEY_GOT1) begin
                nxt_key_state = KEY_ARMED; // RULE8
            end else begin
                nxt_key_state = KEY_IDLE; // any other access closes the window
            end
        end
    end

    // write-enable bit: clearing always allowed, setting only when armed
    reg nxt_wren;
    always @* begin
        nxt_wren = timer_write_enable_ff;
        if (wr && hit_cfg && hi_lane) begin
            if (!pwdata[`WREN_BIT]) begin
                nxt_wren = 1'b0;
            end else if (key_state_ff == KEY_ARMED) begin
                nxt_wren = 1'b1; // RULE8
            end
        end
    end

    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            minutes_ff <= 8'h00;
            seconds_ff <= 8'h00;
            weekday_ff <= 8'h00;
            hours_ff <= 8'h00;
            month_ff <= 8'h00;
            day_ff <= 8'h00;
            year_ff <= 8'h00;
            alarm_minutes_ff <= 8'h00;
            alarm_seconds_ff <= 8'h00;
            alarm_weekday_ff <= 8'h00;
            alarm_hours_ff <= 8'h00;
            alarm_month_ff <= 8'h00;
            alarm_day_of_month_ff <= 8'h00;
            timer_write_enable_ff <= 1'b0;
            cfg_rest_ff <= 16'h0000;
            alarm_cfg_rest_ff <= 16'h0000;
            reference_clock_select_ff <= `CLK_SECONDARY_OSCILLATOR;
            key_state_ff <= KEY_IDLE;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            key_state_ff <= nxt_key_state;
            timer_write_enable_ff <= nxt_wren;
            // timer writes are dropped silently while locked
            if (wr && hit_time && timer_wr_ok) begin // RULE7
                case (time_pointer)
                    `PTR_MIN_SEC: begin
                        if (hi_lane) minutes_ff <= pwdata[15:8];
                        if (lo_lane) seconds_ff <= pwdata[7:0];
                    end
                    `PTR_WD_HR: begin
                        if (hi_lane) weekday_ff <= pwdata[15:8];
                        if (lo_lane) hours_ff <= pwdata[7:0];
                    end
                    `PTR_MON_DAY: begin
                        if (hi_lane) month_ff <= pwdata[15:8];
                        if (lo_lane) day_ff <= pwdata[7:0];
                    end
                    default: begin
                        if (lo_lane) year_ff <= pwdata[7:0];
                    end
                endcase
            end
            // alarm registers are not behind the lock
            if (wr && hit_alarm) begin
                case (alarm_pointer)
                    `PTR_MIN_SEC: begin
                        if (hi_lane) alarm_minutes_ff <= pwdata[15:8];
                        if (lo_lane) alarm_seconds_ff <= pwdata[7:0];
                    end
                    `PTR_WD_HR: begin
                        if (hi_lane) alarm_weekday_ff <= pwdata[15:8];
                        if (lo_lane) alarm_hours_ff <= pwdata[7:0];
                    end
                    `PTR_MON_DAY: begin
                        if (hi_lane) alarm_month_ff <= pwdata[15:8];
                        if (lo_lane) alarm_day_of_month_ff <= pwdata[7:0];
                    end
                    default: begin
                        alarm_month_ff <= alarm_month_ff; // 11 maps to nothing
                    end
                endcase
            end
            if (wr && hit_cfg) begin
                if (lo_lane) cfg_rest_ff[7:0] <= pwdata[7:0];
                if (hi_lane) cfg_rest_ff[15:8] <= pwdata[15:8] & 8'hDC; // pointer and enable live elsewhere
            end
            if (wr && hit_acfg) begin
                if (lo_lane) alarm_cfg_rest_ff[7:0] <= pwdata[7:0];
                if (hi_lane) alarm_cfg_rest_ff[15:8] <= pwdata[15:8] & 8'hFC;
            end
            if (wr && hit_pwr && hi_lane) begin
                reference_clock_select_ff <= pwdata[`CLKSEL_HI:`CLKSEL_LO];
            end
            // zero wait state: ready in the access phase
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) begin
                prdata <= nxt_prdata;
            end
        end
    end

    // reference source mux
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_clock <= 1'b0;
            line_60hz <= 1'b0;
        end else if (clk_en) begin
            case (reference_clock_select_ff)
                `CLK_SECONDARY_OSCILLATOR: ref_clock <= secondary_oscillator_s; // RULE10
                `CLK_LOW_POWER_RC_OSCILLATOR: ref_clock <= low_power_rc_oscillator_s; // RULE10
                `CLK_LINE50: ref_clock <= line_s; // RULE11
                default: ref_clock <= line_s; // RULE11
            endcase
            line_60hz <= (reference_clock_select_ff == `CLK_LINE60); // RULE11
        end
    end
endmodule
`default_nettype wire

// ---- rtc_window_access_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"
module rtc_window_access_properties #(
    parameter ADDR_W = 12
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire secondary_oscillator,
    input wire low_power_rc_oscillator,
    input wire line_clock,
    input wire ref_clock,
    input wire line_60hz
);
    reg [1:0] key_ff;
    reg [1:0] sel_ff;
    reg wren_ff;
    reg [2:0] hold_ff;
    wire wr = psel && penable && clk_en && pwrite;
    wire kw = wr && paddr == `ADDR_UNLOCK_KEY && pstrb[0];
    wire mapped = paddr <= `ADDR_REF_STATUS && paddr[1:0] == 2'h0;
    wire src = sel_ff == 2'h0 ? secondary_oscillator : sel_ff == 2'h1 ? low_power_rc_oscillator : line_clock;

    // mirror of key arming, write enable and source select; any other access disarms the key
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_ff <= 2'h0;
            sel_ff <= 2'h0;
            wren_ff <= 1'b0;
            hold_ff <= 3'h0;
        end else begin
            if (psel && penable && clk_en) begin
                key_ff <= (kw && pwdata[7:0] == `KEY_FIRST) ? 2'h1 :
                    (kw && pwdata[7:0] == `KEY_SECOND && key_ff == 2'h1) ? 2'h2 : 2'h0;
            end
            if (wr && paddr == `ADDR_CFG_CAL && pstrb[1] && (!pwdata[`WREN_BIT] || key_ff == 2'h2)) begin
                wren_ff <= pwdata[`WREN_BIT];
            end
            // hold counts edges since the last select change, so synchroniser latency has settled
            if (wr && paddr == `ADDR_PWR_CTRL && pstrb[1]) begin
                sel_ff <= pwdata[`CLKSEL_HI:`CLKSEL_LO];
                hold_ff <= 3'h0;
            end else if (!clk_en) begin
                // a frozen pipeline breaks the fixed latency, so start counting again
                hold_ff <= 3'h0;
            end else if (hold_ff != 3'h7) begin
                hold_ff <= hold_ff + 3'h1;
            end
        end
    end

    sequence setup_s;
        psel && !penable && clk_en;
    endsequence
    sequence status_rd_s;
        setup_s ##0 (!pwrite && paddr == `ADDR_REF_STATUS);
    endsequence
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_after_setup_a: assert property (setup_s |=> pready)
        else $error("no ready one cycle after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    unmapped_err_a: assert property (setup_s ##0 !mapped |=> pready && pslverr)
        else $error("unmapped access not flagged");
    unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    wren_status_a: assert property (status_rd_s |=> prdata[0] == wren_ff)
        else $error("write enable state wrong");
    ref_osc_a: assert property (hold_ff >= 3'h4 && sel_ff <= 2'h1 |-> ref_clock == $past(src, 3))
        else $error("oscillator reference not followed");
    ref_line_a: assert property (hold_ff >= 3'h4 && sel_ff >= 2'h2 |-> ref_clock == $past(src, 3))
        else $error("line reference not followed");
    line_flag_a: assert property (hold_ff >= 3'h2 |-> line_60hz == (sel_ff == 2'h3))
        else $error("line rate flag wrong");
endmodule

bind rtc_window_access rtc_window_access_properties #(.ADDR_W(ADDR_W)) rtc_window_access_properties_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .secondary_oscillator(secondary_oscillator),
    .low_power_rc_oscillator(low_power_rc_oscillator), .line_clock(line_clock),
    .ref_clock(ref_clock), .line_60hz(line_60hz)
);
`default_nettype wire

// ---- rtc_window_access_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"
module rtc_window_access_test;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic secondary_oscillator, low_power_rc_oscillator, line_clock, ref_clock, line_60hz;
    int err_count, cmp_count, i, j;

    // clock enable is dropped once, with the bus idle, to see the reference path freeze
    rtc_window_access #(.ADDR_W(12)) rtc_window_access_inst (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .secondary_oscillator(secondary_oscillator),
        .low_power_rc_oscillator(low_power_rc_oscillator), .line_clock(line_clock),
        .ref_clock(ref_clock), .line_60hz(line_60hz)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic report_and_stop();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until ready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            report_and_stop();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wrw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        xfer(1'b1, a, d, s);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'h3);
        check(rd, exp);
    endtask

    task automatic unlock();
        wrw(`ADDR_UNLOCK_KEY, {24'h0, `KEY_FIRST}, 4'h1);
        wrw(`ADDR_UNLOCK_KEY, {24'h0, `KEY_SECOND}, 4'h1);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {secondary_oscillator, low_power_rc_oscillator, line_clock} = 3'h0;
        clk_en = 1'b1;
        err_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`ADDR_REF_STATUS, 32'h0);
        // enable without key, and with an access between key and set, must not take
        wrw(`ADDR_CFG_CAL, 32'h2000, 4'h3);
        rdc(`ADDR_REF_STATUS, 32'h0);
        unlock();
        rdc(`ADDR_REF_STATUS, 32'h0);
        wrw(`ADDR_CFG_CAL, 32'h2000, 4'h3);
        rdc(`ADDR_REF_STATUS, 32'h0);
        unlock();
        wrw(`ADDR_CFG_CAL, 32'h2300, 4'h3);
        rdc(`ADDR_REF_STATUS, 32'h1);
        // fill time pairs from pointer 11 down, then one more at the floor
        for (i = 3; i >= 0; i--) begin
            wrw(`ADDR_TIME_WIN, 32'hA0B0 + i * 32'h0101, 4'h3);
            rdc(`ADDR_CFG_CAL, 32'h2000 + ((i == 0 ? 0 : i - 1) << 8));
        end
        wrw(`ADDR_TIME_WIN, 32'h5A3C, 4'h3);
        rdc(`ADDR_CFG_CAL, 32'h2000);
        wrw(`ADDR_CFG_CAL, 32'h0300, 4'h3);
        for (i = 3; i >= 0; i--) begin
            rdc(`ADDR_TIME_WIN, i == 3 ? 32'h00B3 : i == 0 ? 32'h5A3C : 32'hA0B0 + i * 32'h0101);
        end
        rdc(`ADDR_TIME_WIN, 32'h5A3C);
        rdc(`ADDR_CFG_CAL, 32'h0);
        // write enable now clear: the time write is dropped
        wrw(`ADDR_TIME_WIN, 32'h0F0F, 4'h3);
        rdc(`ADDR_TIME_WIN, 32'h5A3C);
        // alarm window: low lane write does not step, word writes step once each
        wrw(`ADDR_ALARM_CFG, 32'h0300, 4'h3);
        wrw(`ADDR_ALARM_WIN, 32'h0077, 4'h1);
        rdc(`ADDR_ALARM_CFG, 32'h0300);
        for (i = 3; i >= 0; i--) begin
            wrw(`ADDR_ALARM_WIN, 32'hC0D0 + i * 32'h0101, 4'h3);
        end
        rdc(`ADDR_ALARM_CFG, 32'h0);
        wrw(`ADDR_ALARM_CFG, 32'h0300, 4'h3);
        for (i = 3; i >= 0; i--) begin
            rdc(`ADDR_ALARM_WIN, i == 3 ? 32'h0 : 32'hC0D0 + i * 32'h0101);
        end
        rdc(`ADDR_ALARM_WIN, 32'hC0D0);
        wrw(`ADDR_ALARM_CFG, 32'h0100, 4'h3);
        wrw(`ADDR_ALARM_WIN, 32'h9900, 4'h2);
        rdc(`ADDR_ALARM_CFG, 32'h0);
        wrw(`ADDR_ALARM_CFG, 32'h0100, 4'h3);
        rdc(`ADDR_ALARM_WIN, 32'h99D1);
        // each select code must follow only its own source, both levels
        for (i = 0; i < 4; i++) begin
            wrw(`ADDR_PWR_CTRL, i << 8, 4'h3);
            for (j = 1; j >= 0; j--) begin
                @(posedge pclk);
                secondary_oscillator <= (i == 0) == j;
                low_power_rc_oscillator <= (i == 1) == j;
                line_clock <= (i >= 2) == j;
                repeat (6) @(posedge pclk);
                rdc(`ADDR_REF_STATUS, {29'h0, i == 3, j[0], 1'b0});
            end
        end
        // frozen clock enable: a line edge must not reach the reference until released
        clk_en <= 1'b0;
        line_clock <= 1'b1;
        repeat (6) @(posedge pclk);
        check({31'h0, ref_clock}, 32'h0);
        clk_en <= 1'b1;
        repeat (6) @(posedge pclk);
        rdc(`ADDR_REF_STATUS, 32'h6);
        // unmapped place: flagged, write dropped, read zero
        wrw(12'h01C, 32'hFFFF, 4'h3);
        check({31'h0, err}, 32'h1);
        rdc(12'h01C, 32'h0);
        check({31'h0, err}, 32'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
